// >>> hw/srf_unit.sv
// The register addresses and the Wishbone slave port were chosen for this implementation.
`timescale 1ns/10ps
module srf_unit (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [4:0] i_wb_adr,
   input wire logic [3:0] i_wb_sel,
   input wire logic [31:0] i_wb_dat,
   output logic [31:0] o_wb_dat,
   output logic o_wb_ack,
   output logic o_busy
);
   logic ack_q;
   logic [31:0] rdat_q;
   logic [31:0] rdat_d;
   logic [15:0] operand_q;
   logic [7:0] imm_cnt_q;
   logic [7:0] cnt_reg_q;
   logic [15:0] acc_q;
   logic [15:0] flags_q;
   logic [15:0] flags_d;
   logic [5:0] ctrl_q;
   logic [15:0] work_q;
   logic [15:0] work_d;
   logic [7:0] temp_q;
   logic cf_q;
   logic cf_d;
   logic orig_sign_q;
   logic one_step_q;
   srf_pkg::srf_state_e state_q;

   // Merge write data into a 16-bit register under the two low byte lanes
   function automatic logic [15:0] lane_merge(input logic [15:0] old, input logic [31:0] dat,
                                              input logic [3:0] sel);
      lane_merge = {sel[1] ? dat[15:8] : old[15:8], sel[0] ? dat[7:0] : old[7:0]};
   endfunction

   // One step of the selected shift; returns {carry, value}, upper byte kept in byte mode
   function automatic logic [16:0] step(input logic [15:0] w, input logic word,
                                        input logic [2:0] op);
      logic [16:0] r;
      r = {1'b0, w};
      if (word) begin
         case (op)
            srf_pkg::OP_ROTATE_RIGHT: r = {w[0], w[0], w[15:1]};
            srf_pkg::OP_ARITH_RIGHT: r = {w[0], w[15], w[15:1]};
            default: r = {w[15], w[14:0], 1'b0};
         endcase
      end else begin
         case (op)
            srf_pkg::OP_ROTATE_RIGHT: r = {w[0], w[15:8], w[0], w[7:1]};
            srf_pkg::OP_ARITH_RIGHT: r = {w[0], w[15:8], w[7], w[7:1]};
            default: r = {w[7], w[15:8], w[6:0], 1'b0};
         endcase
      end
      step = r;
   endfunction

   // Bus decode
   wire logic req = i_wb_cyc & i_wb_stb;
   wire logic wr_fire = req & i_wb_we & ack_q;
   wire logic [3:0] wsel = i_wb_sel;
   wire logic busy = (state_q == srf_pkg::ST_RUN);
   wire logic start = wr_fire & (i_wb_adr == srf_pkg::REG_CTRL) & ~busy;
   wire logic [2:0] new_op = i_wb_dat[srf_pkg::CTRL_OP_LSB +: 3];
   wire logic new_word = i_wb_dat[srf_pkg::CTRL_WORD];
   wire logic [7:0] new_count = i_wb_dat[srf_pkg::CTRL_CNT_SRC] ? cnt_reg_q : imm_cnt_q; // see RULE11
   wire logic [2:0] op = ctrl_q[srf_pkg::CTRL_OP_LSB +: 3];
   wire logic word = ctrl_q[srf_pkg::CTRL_WORD];
   wire logic [16:0] stepped = step(work_q, word, op);
   wire logic done = busy & (temp_q == 8'h00);
   wire logic res_msb = word ? work_q[15] : work_q[7];
   wire logic res_next = word ? work_q[14] : work_q[6];
   wire logic res_zero = word ? (work_q == 16'h0000) : (work_q[7:0] == 8'h00);
   wire logic is_ror = (op == srf_pkg::OP_ROTATE_RIGHT);
   wire logic is_sar = (op == srf_pkg::OP_ARITH_RIGHT);
   wire logic shl_ovf = one_step_q ? (res_msb ^ cf_q) : (res_msb ^ orig_sign_q); // see RULE8

   // Read mux; unmapped offsets read as zero
   always_comb begin
      rdat_d = 32'h00000000;
      case (i_wb_adr)
         srf_pkg::REG_OPERAND: rdat_d = {16'h0000, operand_q};
         srf_pkg::REG_IMM_COUNT: rdat_d = {24'h000000, imm_cnt_q};
         srf_pkg::REG_COUNT: rdat_d = {24'h000000, cnt_reg_q};
         srf_pkg::REG_ACC: rdat_d = {16'h0000, acc_q};
         srf_pkg::REG_FLAGS: rdat_d = {16'h0000, flags_q};
         srf_pkg::REG_CTRL: rdat_d = {23'h0, busy, 2'h0, ctrl_q};
         srf_pkg::REG_RESULT: rdat_d = {16'h0000, work_q};
         default: rdat_d = 32'h00000000;
      endcase
   end

   // Next flags: flag load at start, shift flags at completion, software write when idle
   always_comb begin
      flags_d = flags_q;
      if (start && new_op == srf_pkg::OP_FLAGS_FROM_ACC) begin
         flags_d[srf_pkg::SIGN_FLAG] = acc_q[15]; // see RULE3
         flags_d[srf_pkg::ZERO_FLAG] = acc_q[14]; // see RULE3
         flags_d[srf_pkg::AUX_CARRY_FLAG] = acc_q[12]; // see RULE3
         flags_d[srf_pkg::PARITY_FLAG] = acc_q[10]; // see RULE3, RULE4
         flags_d[srf_pkg::CARRY_FLAG] = acc_q[8]; // see RULE3, RULE4
      end else if (done) begin
         flags_d[srf_pkg::CARRY_FLAG] = cf_q; // see RULE1, RULE5, RULE9
         if (is_ror) begin
            flags_d[srf_pkg::OVERFLOW_FLAG] = res_msb ^ res_next; // see RULE2
         end else begin
            // Rotate leaves sign, zero and parity alone; shifts update them
            flags_d[srf_pkg::OVERFLOW_FLAG] = is_sar ? 1'b0 : shl_ovf; // see RULE8, RULE7
            flags_d[srf_pkg::SIGN_FLAG] = res_msb; // see RULE12
            flags_d[srf_pkg::ZERO_FLAG] = res_zero;
            flags_d[srf_pkg::PARITY_FLAG] = ~^work_q[7:0];
         end
      end else if (wr_fire && !busy && i_wb_adr == srf_pkg::REG_FLAGS) begin
         flags_d = lane_merge(flags_q, i_wb_dat, wsel);
      end
   end

   // Work value and carry stepping
   always_comb begin
      work_d = work_q;
      cf_d = cf_q;
      if (start) begin
         work_d = operand_q;
         cf_d = flags_q[srf_pkg::CARRY_FLAG];
      end else if (busy && temp_q != 8'h00) begin
         work_d = stepped[15:0]; // see RULE1, RULE5, RULE6, RULE9, RULE10
         cf_d = stepped[16];
      end
   end

   // Wishbone ack drops in the cycle after it is given
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ack_q <= 1'b0;
         rdat_q <= 32'h00000000;
      end else begin
         ack_q <= req & ~ack_q;
         rdat_q <= rdat_d;
      end
   end

   // Software registers; writes take effect at the ack edge
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         operand_q <= srf_pkg::RST_WORD;
         imm_cnt_q <= srf_pkg::RST_BYTE;
         cnt_reg_q <= srf_pkg::RST_BYTE;
         acc_q <= srf_pkg::RST_WORD;
         ctrl_q <= 6'h00;
      end else if (wr_fire) begin
         case (i_wb_adr)
            srf_pkg::REG_OPERAND: operand_q <= lane_merge(operand_q, i_wb_dat, wsel);
            srf_pkg::REG_IMM_COUNT: imm_cnt_q <= wsel[0] ? i_wb_dat[7:0] : imm_cnt_q;
            srf_pkg::REG_COUNT: cnt_reg_q <= wsel[0] ? i_wb_dat[7:0] : cnt_reg_q;
            srf_pkg::REG_ACC: acc_q <= lane_merge(acc_q, i_wb_dat, wsel);
            srf_pkg::REG_CTRL: ctrl_q <= busy ? ctrl_q : i_wb_dat[5:0];
            default: ctrl_q <= ctrl_q;
         endcase
      end
   end

   // Step engine: one count step per clock, so a nonzero shift count of n keeps busy high for n+1 cycles
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_q <= srf_pkg::ST_IDLE;
         temp_q <= srf_pkg::RST_BYTE;
         orig_sign_q <= 1'b0;
         one_step_q <= 1'b0;
         work_q <= srf_pkg::RST_WORD;
         cf_q <= 1'b0;
         flags_q <= srf_pkg::RST_WORD;
      end else begin
         work_q <= work_d;
         cf_q <= cf_d;
         flags_q <= flags_d;
         if (start && new_op != srf_pkg::OP_FLAGS_FROM_ACC && new_count != 8'h00) begin
            state_q <= srf_pkg::ST_RUN;
            temp_q <= new_count;
            one_step_q <= (new_count == 8'h01);
            orig_sign_q <= new_word ? operand_q[15] : operand_q[7];
         end else if (busy && temp_q != 8'h00) begin
            temp_q <= temp_q - 8'h01;
         end else if (done) begin
            state_q <= srf_pkg::ST_IDLE;
         end
      end
   end

   assign o_wb_ack = ack_q;
   assign o_wb_dat = ack_q ? rdat_q : 32'h00000000;
   assign o_busy = busy;

   property p_flag_load;
      @(posedge i_clk) disable iff (!i_rst_n)
      (start && new_op == srf_pkg::OP_FLAGS_FROM_ACC) |=>
         flags_q[7:0] == {$past(acc_q[15:14]), $past(flags_q[5]), $past(acc_q[12]),
                          $past(flags_q[3]), $past(acc_q[10]), $past(flags_q[1]), $past(acc_q[8])};
   endproperty
   a_flag_load: assert property (p_flag_load) else $error("flag load mismatch"); // see RULE3

   property p_flag_load_keep;
      @(posedge i_clk) disable iff (!i_rst_n)
      (start && new_op == srf_pkg::OP_FLAGS_FROM_ACC) |=> $stable(flags_q[15:8]);
   endproperty
   a_flag_load_keep: assert property (p_flag_load_keep) else $error("flag load touched others"); // see RULE4

   property p_ror_step;
      @(posedge i_clk) disable iff (!i_rst_n)
      (busy && temp_q != 8'h00 && is_ror && word) |=>
         work_q == {$past(work_q[0]), $past(work_q[15:1])} && cf_q == $past(work_q[0]);
   endproperty
   a_ror_step: assert property (p_ror_step) else $error("rotate step wrong"); // see RULE1

   property p_shl_step;
      @(posedge i_clk) disable iff (!i_rst_n)
      (busy && temp_q != 8'h00 && !is_ror && !is_sar && !word) |=>
         work_q[7:0] == {$past(work_q[6:0]), 1'b0} && cf_q == $past(work_q[7]);
   endproperty
   a_shl_step: assert property (p_shl_step) else $error("left shift step wrong"); // see RULE5, RULE6

   property p_sar_step;
      @(posedge i_clk) disable iff (!i_rst_n)
      (busy && temp_q != 8'h00 && is_sar && word) |=>
         $signed(work_q) == ($signed($past(work_q)) >>> 1) && cf_q == $past(work_q[0]);
   endproperty
   a_sar_step: assert property (p_sar_step) else $error("arith right step wrong"); // see RULE9, RULE10

   property p_ror_ovf;
      @(posedge i_clk) disable iff (!i_rst_n)
      (done && is_ror && one_step_q) |=>
         flags_q[srf_pkg::OVERFLOW_FLAG] == ($past(res_msb) ^ $past(res_next))
         && $stable(flags_q[srf_pkg::SIGN_FLAG]);
   endproperty
   a_ror_ovf: assert property (p_ror_ovf) else $error("rotate overflow wrong"); // see RULE2, RULE12

   property p_shl_ovf;
      @(posedge i_clk) disable iff (!i_rst_n)
      (done && one_step_q && (op == srf_pkg::OP_LOGICAL_LEFT || op == srf_pkg::OP_ARITH_LEFT)) |=>
         flags_q[srf_pkg::OVERFLOW_FLAG] == ($past(res_msb) ^ flags_q[srf_pkg::CARRY_FLAG]);
   endproperty
   a_shl_ovf: assert property (p_shl_ovf) else $error("left shift overflow wrong"); // see RULE8, RULE7

   property p_count_src;
      @(posedge i_clk) disable iff (!i_rst_n)
      (start && new_op != srf_pkg::OP_FLAGS_FROM_ACC && i_wb_dat[srf_pkg::CTRL_CNT_SRC]
       && cnt_reg_q == 8'h03) |=> busy [*3] ##1 done ##1 !busy;
   endproperty
   a_count_src: assert property (p_count_src) else $error("count register not used"); // see RULE11

   property p_ack;
      @(posedge i_clk) disable iff (!i_rst_n)
      (req && !ack_q) |=> ack_q ##1 !ack_q;
   endproperty
   a_ack: assert property (p_ack) else $error("bus ack timing wrong");
endmodule

// >>> hw/srf_pkg.sv
// How it works
// RULE1 - Rotate right moves lowest bit into carry and into top bit, once per step.
// RULE2 - Rotate right by one sets overflow when two top result bits differ.
// RULE3 - Flag load copies acc high bits 7,6,4,2,0 to sign,zero,aux,parity,carry.
// RULE4 - Flag load overwrites those five flags fully and leaves the others alone.
// RULE5 - Left shift moves the top bit into carry on every step.
// RULE6 - Left shift inserts a zero at the lowest bit on every step.
// RULE7 - Logical and arithmetic left shift are one operation with the same flags.
// RULE8 - Left shift overflow clears when sign keeps its value; by one, top differs carry.
// RULE9 - Arithmetic right shift refills the top with the sign, lowest bit to carry.
// RULE10 - Arithmetic right shift rounds negatives toward minus infinity.
// RULE11 - Destination is register or memory; count is immediate or count register. CTRL_DEST_MEM is unused; result is in REG_RESULT.
// RULE12 - Unaffected flags hold, updated flags get new values, undefined ones are free.
package srf_pkg;
   // Register byte offsets
   localparam logic [4:0] REG_OPERAND = 5'h00;
   localparam logic [4:0] REG_IMM_COUNT = 5'h04;
   localparam logic [4:0] REG_COUNT = 5'h08;
   localparam logic [4:0] REG_ACC = 5'h0c;
   localparam logic [4:0] REG_FLAGS = 5'h10;
   localparam logic [4:0] REG_CTRL = 5'h14;
   localparam logic [4:0] REG_RESULT = 5'h18;
   // Control field positions
   localparam int CTRL_OP_LSB = 0;
   localparam int CTRL_WORD = 3;
   localparam int CTRL_CNT_SRC = 4;
   localparam int CTRL_DEST_MEM = 5;
   localparam int CTRL_BUSY = 8;
   // Operation codes
   localparam logic [2:0] OP_ROTATE_RIGHT = 3'h0;
   localparam logic [2:0] OP_LOGICAL_LEFT = 3'h1;
   localparam logic [2:0] OP_ARITH_LEFT = 3'h2;
   localparam logic [2:0] OP_ARITH_RIGHT = 3'h3;
   localparam logic [2:0] OP_FLAGS_FROM_ACC = 3'h4;
   // Flag bit positions
   localparam int CARRY_FLAG = 0;
   localparam int PARITY_FLAG = 2;
   localparam int AUX_CARRY_FLAG = 4;
   localparam int ZERO_FLAG = 6;
   localparam int SIGN_FLAG = 7;
   localparam int OVERFLOW_FLAG = 11;
   // Reset values
   localparam logic [15:0] RST_WORD = 16'h0000;
   localparam logic [7:0] RST_BYTE = 8'h00;
   typedef enum logic {ST_IDLE, ST_RUN} srf_state_e;
endpackage

// >>> bench/srf_host.sv
`timescale 1ns/10ps
// Stand-in for the decoder and register file: a classic bus master, one cycle at a time
module srf_host (
   input wire logic i_clk,
   input wire logic i_ack,
   input wire logic [31:0] i_dat,
   output logic o_cyc = 1'b0,
   output logic o_stb = 1'b0,
   output logic o_we = 1'b0,
   output logic [4:0] o_adr = 5'h00,
   output logic [3:0] o_sel = 4'h0,
   output logic [31:0] o_dat = 32'h00000000
);
   // Holds the whole request until ack is sampled high, then releases it
   task automatic xfer(input logic w, input logic [4:0] a, input logic [31:0] d,
                       output logic [31:0] q);
      @(posedge i_clk);
      o_cyc <= 1'b1;
      o_stb <= 1'b1;
      o_we <= w;
      o_adr <= a;
      o_sel <= 4'hf;
      o_dat <= d;
      @(posedge i_clk);
      while (i_ack !== 1'b1) begin
         @(posedge i_clk);
      end
      q = i_dat;
      o_cyc <= 1'b0;
      o_stb <= 1'b0;
      o_we <= 1'b0;
      o_dat <= ~d;  // Released data must not look like the last word
   endtask
endmodule

// >>> bench/srf_unit_tb.sv
`timescale 1ns/10ps
module srf_unit_tb;
   logic i_clk = 1'b0;
   logic i_rst_n = 1'b0;
   logic cyc, stb, we, ack, busy;
   logic [4:0] adr;
   logic [3:0] sel;
   logic [31:0] wdat, rdat, q;
   int bad_count = 0;
   int n_tests = 0;
   int tick = 0;

   // 40 MHz core clock
   always #12.5 i_clk = ~i_clk;

   srf_unit DUT (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_wb_cyc(cyc), .i_wb_stb(stb),
      .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat),
      .o_wb_ack(ack), .o_busy(busy));
   srf_host u_host (.i_clk(i_clk), .i_ack(ack), .i_dat(rdat), .o_cyc(cyc), .o_stb(stb),
      .o_we(we), .o_adr(adr), .o_sel(sel), .o_dat(wdat));

   task automatic results();
      if (bad_count == 0 && n_tests > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      u_host.xfer(1'b1, a, {16'h0000, d}, q);
   endtask

   task automatic rd(input logic [4:0] a, output logic [31:0] v);
      u_host.xfer(1'b0, a, 32'h00000000, v);
   endtask

   // Loads operands with a decoy count in the unused register, runs, times busy, compares
   task automatic op(input logic [2:0] code, input logic w, input logic src,
      input logic [7:0] cnt, input logic [15:0] opnd, input logic [15:0] flg,
      input logic [15:0] res, input logic [15:0] eflg, input int ebusy);
      int n;
      wr(srf_pkg::REG_OPERAND, opnd);
      wr(srf_pkg::REG_FLAGS, flg);
      wr(src ? srf_pkg::REG_COUNT : srf_pkg::REG_IMM_COUNT, {8'h00, cnt});
      wr(src ? srf_pkg::REG_IMM_COUNT : srf_pkg::REG_COUNT, 16'h0007);
      wr(srf_pkg::REG_CTRL, {10'h000, w ^ src, src, w, code});
      n = 0;
      @(negedge i_clk);
      while (busy === 1'b1 && n < 300) begin
         n++;
         @(negedge i_clk);
      end
      chk(32'(n), 32'(ebusy));
      rd(srf_pkg::REG_RESULT, q);
      chk(q, {16'h0000, res});
      rd(srf_pkg::REG_FLAGS, q);
      chk(q, {16'h0000, eflg});
   endtask

   // Cleared result register, unmapped place ignores writes and reads zero
   task automatic t_reset();
      rd(srf_pkg::REG_RESULT, q);
      chk(q, 32'h00000000);
      wr(5'h1c, 16'hffff);
      rd(5'h1c, q);
      chk(q, 32'h00000000);
   endtask

   // Low byte of the accumulator must not leak into the flags
   task automatic t_flag_load();
      wr(srf_pkg::REG_ACC, 16'h00aa);
      op(srf_pkg::OP_FLAGS_FROM_ACC, 1'b1, 1'b0, 8'h01, 16'h0000, 16'hffff, 16'h0000, 16'hff2a, 0);
      wr(srf_pkg::REG_ACC, 16'hd500);
      op(srf_pkg::OP_FLAGS_FROM_ACC, 1'b0, 1'b1, 8'h01, 16'h0000, 16'h0000, 16'h0000, 16'h00d5, 0);
   endtask

   task automatic t_ror();
      op(srf_pkg::OP_ROTATE_RIGHT, 1'b1, 1'b0, 8'h01, 16'h0001, 16'h00d4, 16'h8000, 16'h08d5, 2);
      op(srf_pkg::OP_ROTATE_RIGHT, 1'b0, 1'b1, 8'h03, 16'hab05, 16'h0000, 16'haba0, 16'h0801, 4);
   endtask

   // Both left forms must agree; a full byte shift leaves zeros
   task automatic t_left();
      logic [2:0] codes [2] = '{srf_pkg::OP_LOGICAL_LEFT, srf_pkg::OP_ARITH_LEFT};
      foreach (codes[i]) begin
         op(codes[i], 1'b1, 1'b0, 8'h01, 16'h4001, 16'h0000, 16'h8002, 16'h0880, 2);
         op(codes[i], 1'b0, 1'b1, 8'h08, 16'h12ff, 16'h0010, 16'h1200, 16'h0855, 9);
      end
   endtask

   // Minus five halves to minus three
   task automatic t_sar();
      op(srf_pkg::OP_ARITH_RIGHT, 1'b1, 1'b0, 8'h01, 16'hfffb, 16'h0010, 16'hfffd, 16'h0091, 2);
      op(srf_pkg::OP_ARITH_RIGHT, 1'b0, 1'b1, 8'h02, 16'h7f80, 16'h0801, 16'h7fe0, 16'h0080, 3);
   endtask

   // Count zero runs no step; the start still copies the operand into the result
   task automatic t_count0();
      op(srf_pkg::OP_LOGICAL_LEFT, 1'b1, 1'b0, 8'h00, 16'h1234, 16'h0801, 16'h1234, 16'h0801, 0);
   endtask

   // Start and flag writes during a run are refused
   task automatic t_busy();
      wr(srf_pkg::REG_ACC, 16'hff00);
      wr(srf_pkg::REG_OPERAND, 16'h0001);
      wr(srf_pkg::REG_FLAGS, 16'h0000);
      wr(srf_pkg::REG_IMM_COUNT, 16'h0005);
      wr(srf_pkg::REG_CTRL, {13'h0008 >> 3, srf_pkg::OP_ROTATE_RIGHT} | 16'h0008);
      wr(srf_pkg::REG_CTRL, {13'h0000, srf_pkg::OP_FLAGS_FROM_ACC});
      wr(srf_pkg::REG_FLAGS, 16'hffff);
      while (busy !== 1'b0) @(posedge i_clk);
      rd(srf_pkg::REG_RESULT, q);
      chk(q, 32'h00000800);
      rd(srf_pkg::REG_FLAGS, q);
      chk(q, 32'h00000000);
   endtask

   // Watchdog far beyond the expected run length
   always @(posedge i_clk) begin
      tick++;
      if (tick == 5000) begin
         bad_count++;
         results();
      end
   end

   initial begin
      repeat (2) @(posedge i_clk);
      i_rst_n <= 1'b1;
      t_reset();
      t_flag_load();
      t_ror();
      t_left();
      t_sar();
      t_count0();
      t_busy();
      results();
   end
endmodule
